/* shared/hpft_pkg.sv */
// package: register map, field layout and timing constants for the host port paging block
//
// Notes on behaviour
// - the 32-bit trim word is a signed offset shared by all four synthesizers
// - numeric oscillator mode: output equals initial frequency times one plus trim over 2^32
// - lockout bit set makes every other port register read-only; clear reopens writes
// - guard bit 0 flags a failed host access; bits 6:0 read zero after success, lockout bit kept except on a guard write
// - unsigned 8-bit bank choice picks which 128-byte page the window reaches
// - pages 0-6, 8, 10-13 valid; 7, 9 and 14 upward reserved, never written
package hpft_pkg;

  // ---------------------------------------------------------------------------
  // register offsets inside the window
  // ---------------------------------------------------------------------------
  localparam logic [6:0] GUARD_OFS  = 7'h7e;
  localparam logic [6:0] BANK_OFS   = 7'h7f;
  // trim word occupies four bytes of page 0, most significant byte first
  localparam logic [6:0] TRIM_OFS0  = 7'h0b;
  localparam logic [6:0] TRIM_OFS3  = 7'h0e;

  // ---------------------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int         LOCKOUT_BIT = 7;
  localparam int         STATUS_BIT  = 0;
  localparam logic [7:0]  GUARD_RST  = 8'h00;
  localparam logic [7:0]  BANK_RST   = 8'h00;
  localparam logic [31:0] TRIM_RST   = 32'h046aaaab;
  localparam logic [7:0]  LAST_PAGE  = 8'h0d;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ       = 40_000_000;
  localparam int TRIM_GAP_MS  = 25;
  localparam int TRIM_GAP_CYC = (CLK_HZ / 1000) * TRIM_GAP_MS;

  // host access request as seen by the register logic
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } hpft_req_t;

endpackage

/* hdl/hpft_gap_timer.sv */
// gap timer: busy for a programmable number of cycles after each start pulse
`timescale 1ns/1ps
module hpft_gap_timer #(
  parameter int GAP = 1000
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_start,
  output logic      o_busy
);
  // a zero gap would leave nothing to count
  if (GAP < 1) begin : g_gap_check
    $error("gap must be at least one cycle");
  end

  localparam int W = $clog2(GAP + 1);
  logic [W-1:0] count;

  // --------------------------------------------------------------------------
  // down counter
  // --------------------------------------------------------------------------
  // reload on every start so the gap is measured from the last access;
  // one less than the gap is loaded so an access exactly GAP cycles later is open
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count <= '0;
    end else if (i_start) begin
      count <= W'(GAP - 1);
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign o_busy = (count != '0);
endmodule

/* hdl/hpft_regs.sv */
// host port register logic: paging, guard/lockout and centre frequency trim
`timescale 1ns/1ps
module hpft_regs #(
  parameter int TRIM_GAP = hpft_pkg::TRIM_GAP_CYC
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic                 i_req_valid,
  input  wire hpft_pkg::hpft_req_t  i_req,
  output logic [7:0]                o_rdata,
  output logic                      o_rvalid,
  output logic [10:0]               o_abs_addr,
  output logic                      o_ext_wr,
  output logic [31:0]               o_center_frequency_trim,
  output logic                      o_trim_update
);
  // the spacing checks below need at least a few busy cycles to watch
  if (TRIM_GAP < 4) begin : g_gap_check
    $error("trim gap must be at least four cycles");
  end

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [7:0]  guard;
  logic [7:0]  bank_choice;
  logic [31:0] trim;
  logic        trim_busy;
  logic        on_page0;
  logic        is_guard;
  logic        is_bank;
  logic        is_trim;
  logic        locked;
  logic        bad_page;
  logic        fail;
  logic        wr_ok;
  logic [1:0]  trim_byte;

  // window decode; guard and bank choice appear in every page
  assign on_page0  = (bank_choice == 8'h00);
  assign is_guard  = (i_req.addr == hpft_pkg::GUARD_OFS);
  assign is_bank   = (i_req.addr == hpft_pkg::BANK_OFS);
  assign is_trim   = on_page0 && (i_req.addr >= hpft_pkg::TRIM_OFS0)
                     && (i_req.addr <= hpft_pkg::TRIM_OFS3);
  assign trim_byte = 2'(i_req.addr - hpft_pkg::TRIM_OFS0);
  assign locked    = guard[hpft_pkg::LOCKOUT_BIT];

  // reserved pages hold nothing, so any access there other than guard or bank choice counts as failed
  assign bad_page = (bank_choice == 8'h07) || (bank_choice == 8'h09)
                    || (bank_choice > hpft_pkg::LAST_PAGE);

  // failure: write under lockout, reserved page, trim hit inside the gap
  assign fail = i_req_valid && (
                  (i_req.wr && locked && !is_guard)
                  || (bad_page && !is_guard && !is_bank)
                  || (is_trim && trim_busy));
  assign wr_ok = i_req_valid && i_req.wr && !fail;

  // --------------------------------------------------------------------------
  // guard register
  // --------------------------------------------------------------------------
  // status is rewritten on each access: set on failure, zero after success
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      guard <= hpft_pkg::GUARD_RST;
    end else if (i_req_valid) begin
      if (wr_ok && is_guard) begin
        guard <= {i_req.data[hpft_pkg::LOCKOUT_BIT], 7'h00};
      end else if (!fail) begin
        guard <= {guard[hpft_pkg::LOCKOUT_BIT], 7'h00};
      end
      if (fail) begin
        guard[hpft_pkg::STATUS_BIT] <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // bank choice
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      bank_choice <= hpft_pkg::BANK_RST;
    end else if (wr_ok && is_bank) begin
      bank_choice <= i_req.data;
    end
  end

  // --------------------------------------------------------------------------
  // trim word and its spacing timer
  // --------------------------------------------------------------------------
  // big-endian byte lanes; the word is applied at once to all synthesizers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      trim          <= hpft_pkg::TRIM_RST;
      o_trim_update <= 1'b0;
    end else begin
      o_trim_update <= wr_ok && is_trim;
      if (wr_ok && is_trim) begin
        trim[8*(3-trim_byte) +: 8] <= i_req.data;
      end
    end
  end
  assign o_center_frequency_trim = trim;

  // the timer protects the loop; hosts honouring the gap never see a trim access refused by it
  hpft_gap_timer #(.GAP(TRIM_GAP)) u_gap (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_start  (i_req_valid && is_trim && !fail),
    .o_busy   (trim_busy)
  );

  // --------------------------------------------------------------------------
  // read data and outward access
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata    <= 8'h00;
      o_rvalid   <= 1'b0;
      o_abs_addr <= 11'h000;
      o_ext_wr   <= 1'b0;
    end else begin
      o_rvalid   <= i_req_valid && !i_req.wr;
      o_abs_addr <= {bank_choice[3:0], i_req.addr};
      o_ext_wr   <= wr_ok && !is_guard && !is_bank && !is_trim;
      if (i_req_valid && !i_req.wr) begin
        if (is_guard)      o_rdata <= guard;
        else if (is_bank)  o_rdata <= bank_choice;
        else if (is_trim && !trim_busy) o_rdata <= trim[8*(3-trim_byte) +: 8];
        else               o_rdata <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  property p_lock_blocks;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_req_valid && i_req.wr && locked && is_bank) |=> $stable(bank_choice);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("write passed lockout");

  property p_fail_flag;
    @(posedge i_clk) disable iff (!i_resetn)
    fail |=> guard[0];
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("failure not flagged");

  property p_ok_clear;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_req_valid && !fail && !(i_req.wr && is_guard)) |=> guard[6:0] == 7'h00;
  endproperty
  a_ok_clear: assert property (p_ok_clear) else $error("status not cleared");

  property p_bank_write;
    @(posedge i_clk) disable iff (!i_resetn)
    (wr_ok && is_bank) |=> bank_choice == $past(i_req.data);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank not taken");

  property p_abs;
    @(posedge i_clk) disable iff (!i_resetn)
    i_req_valid |=> o_abs_addr[6:0] == $past(i_req.addr);
  endproperty
  a_abs: assert property (p_abs) else $error("address low bits wrong");

  property p_reserved;
    @(posedge i_clk) disable iff (!i_resetn)
    (bank_choice == 8'h09 && i_req_valid && !is_guard && !is_bank) |=> guard[0];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved page accepted");

  property p_trim_gap;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_trim_update) |-> ##1 (trim_busy [*2]);
  endproperty
  a_trim_gap: assert property (p_trim_gap) else $error("trim gap not held");

  property p_trim_pulse;
    @(posedge i_clk) disable iff (!i_resetn)
    (wr_ok && is_trim) |=> o_trim_update
      && ($past(i_req.data) == trim[8*(3-$past(trim_byte)) +: 8]);
  endproperty
  a_trim_pulse: assert property (p_trim_pulse) else $error("trim byte lost");

  // --------------------------------------------------------------------------
  // independent spacing count for the trim checks
  // --------------------------------------------------------------------------
  // counts cycles from the last accepted trim access, saturating at the gap;
  // kept apart from the timer so a timer off by one shows up here
  logic [31:0] trim_age;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      trim_age <= 32'(TRIM_GAP);
    end else if (i_req_valid && is_trim && !fail) begin
      trim_age <= 32'h0000_0001;
    end else if (trim_age < 32'(TRIM_GAP)) begin
      trim_age <= trim_age + 32'h0000_0001;
    end
  end

  // an accepted trim access never comes sooner than the gap after the last one
  property p_trim_spaced;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_req_valid && is_trim && !fail) |-> trim_age >= 32'(TRIM_GAP);
  endproperty
  a_trim_spaced: assert property (p_trim_spaced) else $error("trim accepted inside gap");

  // once the gap has run out, a trim access that breaks no other rule is taken
  property p_trim_open;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_req_valid && is_trim && !(i_req.wr && locked) && trim_age >= 32'(TRIM_GAP))
      |-> !fail;
  endproperty
  a_trim_open: assert property (p_trim_open) else $error("trim refused after gap");

  // a trim access refused inside the gap flags the failure and leaves the word untouched
  property p_trim_refuse;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_req_valid && is_trim && trim_busy) |=> guard[0] && !o_trim_update && $stable(trim);
  endproperty
  a_trim_refuse: assert property (p_trim_refuse) else $error("refused trim not flagged");
endmodule

/* tb/hpft_host.sv */
// host processor model: one byte access per call, paces trim accesses
`timescale 1ns/1ps
module hpft_host #(
  parameter int GAP = 20
) (
  input  wire logic           i_clk,
  output logic                o_req_valid,
  output hpft_pkg::hpft_req_t o_req
);
  int         since = 0;
  initial begin
    o_req_valid = 1'b0;
    o_req       = '0;
  end
  // cycles since the last trim access, saturating; any page counts, since a
  // refused page write would leave a tracked page copy wrong
  always @(posedge i_clk) begin
    if (o_req_valid && o_req.addr inside {[hpft_pkg::TRIM_OFS0:hpft_pkg::TRIM_OFS3]}) begin
      since <= 0;
    end else if (since < GAP + 4) begin
      since <= since + 1;
    end
  end
  // pace=1 waits out the trim gap first; pace=0 lets a scenario break it
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] data,
                      input bit pace);
    for (int n = 0; pace && n < GAP + 4 && since < GAP + 2; n++) @(posedge i_clk);
    @(negedge i_clk);
    o_req_valid = 1'b1;
    o_req       = '{wr: wr, addr: addr, data: data};
    @(negedge i_clk);
    o_req_valid = 1'b0;
    o_req       = '{wr: 1'b0, addr: ~addr, data: ~data}; // released lines do not hold
  endtask
endmodule

/* tb/hpft_regs_test.sv */
// self-checking bench for the host port register block
`timescale 1ns/1ps
module hpft_regs_test;
  localparam int GAP = 20;
  logic                i_clk    = 1'b0;
  logic                i_resetn = 1'b0;
  logic                req_valid;
  hpft_pkg::hpft_req_t req;
  logic [7:0]          rdata;
  logic                rvalid;
  logic [10:0]         abs_addr;
  logic                ext_wr;
  logic [31:0]         trim;
  logic                trim_upd;
  logic [7:0]          rd;
  logic                xw;
  logic                tu;
  logic [10:0]         aa;
  int                  err_total = 0;
  int                  checks    = 0;
  always #12.5 i_clk = ~i_clk;
  hpft_host #(.GAP(GAP)) host (.i_clk(i_clk), .o_req_valid(req_valid), .o_req(req));
  hpft_regs #(.TRIM_GAP(GAP)) DUT (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(req_valid), .i_req(req),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_abs_addr(abs_addr), .o_ext_wr(ext_wr),
    .o_center_frequency_trim(trim), .o_trim_update(trim_upd));
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  // one access; the answer stands only until the next rising edge, so it is
  // taken at the falling edge where the host releases the request
  task automatic acc(input logic wr, input logic [6:0] a, input logic [7:0] d, input bit p);
    host.xfer(wr, a, d, p);
    rd = rdata;
    xw = ext_wr;
    tu = trim_upd;
    aa = abs_addr;
    if (!wr) chk("rvalid", 1'b1, rvalid);
    else chk("rvalid", 1'b0, rvalid);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    chk("trim", hpft_pkg::TRIM_RST, trim);
    acc(1'b0, 7'h7e, 8'h00, 1'b0);
    chk("guard", 8'h00, rd);
    acc(1'b0, 7'h7f, 8'h00, 1'b0);
    chk("bank", 8'h00, rd);
  endtask
  // every valid page, then every kind of reserved code
  task automatic t_pages;
    logic [7:0] ok[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
                           8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] bad[4] = '{8'h07, 8'h09, 8'h0e, 8'hff};
    foreach (ok[i]) begin
      acc(1'b1, 7'h7f, ok[i], 1'b0);
      acc(1'b1, 7'h05, 8'h3c, 1'b0);
      chk("ext_wr", 1'b1, xw);
      chk("abs_addr", {ok[i][3:0], 7'h05}, aa);
    end
    foreach (bad[i]) begin
      acc(1'b1, 7'h7f, bad[i], 1'b0);
      acc(1'b1, 7'h05, 8'h3c, 1'b0);
      chk("ext_wr", 1'b0, xw);
      acc(1'b0, 7'h7e, 8'h00, 1'b0);
      chk("guard", 8'h01, rd);
    end
    acc(1'b1, 7'h7f, 8'h00, 1'b0);
  endtask
  task automatic t_lock;
    acc(1'b1, 7'h7e, 8'h80, 1'b0);
    acc(1'b1, 7'h7f, 8'h01, 1'b0);
    acc(1'b1, 7'h05, 8'h11, 1'b0);
    chk("ext_wr", 1'b0, xw);
    acc(1'b0, 7'h7e, 8'h00, 1'b0);
    chk("guard", 8'h81, rd);
    acc(1'b1, 7'h7e, 8'h00, 1'b0);
    acc(1'b1, 7'h05, 8'h11, 1'b0);
    chk("ext_wr", 1'b1, xw);
    chk("abs_addr", {4'h0, 7'h05}, aa);
  endtask
  // positive then negative offsets, small enough for any master clock
  task automatic t_trim;
    acc(1'b1, 7'h0e, 8'h55, 1'b1);
    chk("trim_upd", 1'b1, tu);
    chk("trim", 32'h046aaa55, trim);
    acc(1'b1, 7'h0d, 8'h00, 1'b0);
    chk("trim_upd", 1'b0, tu);
    acc(1'b0, 7'h7e, 8'h00, 1'b0);
    chk("guard", 8'h01, rd);
    acc(1'b1, 7'h0b, 8'hff, 1'b1);
    chk("trim", 32'hff6aaa55, trim);
    acc(1'b0, 7'h0b, 8'h00, 1'b1);
    chk("trim_byte", 8'hff, rd);
    acc(1'b0, 7'h0c, 8'h00, 1'b0);
    chk("trim_busy_read", 8'h00, rd);
  endtask
  // reset in mid-run restores every register, lockout included
  task automatic t_reset_again;
    acc(1'b1, 7'h7e, 8'h80, 1'b0);
    @(negedge i_clk);
    i_resetn = 1'b0;
    repeat (2) @(negedge i_clk);
    i_resetn = 1'b1;
    t_reset();
    acc(1'b1, 7'h7f, 8'h02, 1'b0);
    acc(1'b1, 7'h05, 8'h11, 1'b0);
    chk("ext_wr", 1'b1, xw);
    chk("abs_addr", {4'h2, 7'h05}, aa);
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    t_reset();
    t_pages();
    t_lock();
    t_trim();
    t_reset_again();
    close_out();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    close_out();
  end
endmodule
